// >>> inc/asp_pkg.sv
package asp_pkg;

  // ****************************************************************
  // word and clock
  // ****************************************************************
  localparam int          WORD_BITS      = 24;
  localparam int          CLK_PERIOD_NS  = 50;

  // ****************************************************************
  // power modes and conversion modes
  // ****************************************************************
  typedef enum logic [1:0] {
    ASP_PWR_LOW  = 2'h0,
    ASP_PWR_MID  = 2'h1,
    ASP_PWR_FULL = 2'h2
  } asp_pwr_t;

  typedef enum logic [1:0] {
    ASP_CONV_CONT  = 2'h0,
    ASP_CONV_SINGLE = 2'h1,
    ASP_CONV_CREAD = 2'h2
  } asp_conv_t;

  // ****************************************************************
  // ready line states
  // ****************************************************************
  typedef enum logic [3:0] {
    ASP_RDY_IDLE  = 4'h1,
    ASP_RDY_VALID = 4'h2,
    ASP_RDY_READ  = 4'h4,
    ASP_RDY_PULSE = 4'h8
  } asp_rdy_t;

  // ****************************************************************
  // timing: gap between operations in master clock periods
  // ****************************************************************
  localparam int          GAP_FULL_MCLK  = 3;
  localparam int          GAP_MID_MCLK   = 12;
  localparam int          GAP_LOW_MCLK   = 24;
  localparam int          GAP_W          = 5;

  // ready high time on a fresh result while unread, in microseconds
  localparam int          PULSE_FULL_US  = 6;
  localparam int          PULSE_MID_US   = 25;
  localparam int          PULSE_LOW_US   = 50;
  localparam int          PULSE_FULL_CYC = PULSE_FULL_US * 1000 / CLK_PERIOD_NS;
  localparam int          PULSE_MID_CYC  = PULSE_MID_US * 1000 / CLK_PERIOD_NS;
  localparam int          PULSE_LOW_CYC  = PULSE_LOW_US * 1000 / CLK_PERIOD_NS;
  localparam int          PULSE_W        = 11;

  // least time from the last inactive serial edge to the ready level
  localparam int          RDY_FAST_NS    = 10;
  localparam int          RDY_SLOW_NS    = 110;
  localparam int          RDY_FAST_CYC   = (RDY_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RDY_SLOW_CYC   = (RDY_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RDY_W          = 2;

endpackage

// >>> verilog/asp_link.sv
`timescale 1ns/1ps
`default_nettype none

// ******************************************************************
// serial clock side: bit launch and end of word
// ******************************************************************
module asp_link #(
  parameter int WORD_BITS = asp_pkg::WORD_BITS
) (
  input  wire logic                  sclk,
  input  wire logic                  cs_n,
  input  wire logic [WORD_BITS-1:0]  word,
  output logic                       bit_out,
  output logic                       done
);

  localparam int IW = $clog2(WORD_BITS + 1);

  logic [IW-1:0] idx_reg;
  logic [IW-1:0] rise_reg;
  logic [IW-1:0] pos;

  // serial clock stands still between frames, so chip select clears the counters
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      idx_reg <= '0;
    end else if (idx_reg < IW'(WORD_BITS)) begin
      idx_reg <= idx_reg + IW'(1);
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rise_reg <= '0;
    end else if (rise_reg < IW'(WORD_BITS)) begin
      rise_reg <= rise_reg + IW'(1);
    end
  end

  // the first falling edge launches the top bit, so all 24 bits reach 24 rising edges;
  // the count saturates, so the last bit stays on bit_out until chip select rises
  assign pos     = (idx_reg == '0) ? '0 : idx_reg - IW'(1);
  assign bit_out = word[IW'(WORD_BITS - 1) - pos];
  assign done    = (rise_reg == IW'(WORD_BITS));

endmodule
`default_nettype wire

// >>> verilog/asp_port.sv
`timescale 1ns/1ps
`default_nettype none

module asp_port #(
  parameter int WORD_BITS = asp_pkg::WORD_BITS
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  sclk,
  input  wire logic                  cs_n,
  input  wire logic [1:0]            power_mode,
  input  wire logic [1:0]            conv_mode,
  input  wire logic                  cs_hold_bit,
  input  wire logic                  ready_edge_delay_bit,
  input  wire logic [WORD_BITS-1:0]  conv_data,
  input  wire logic                  conv_valid,
  output logic                       dout_o,
  output logic                       dout_oe,
  output logic                       ready_n,
  output logic                       frame_refused
);

  // ****************************************************************
  // decoding used in several places
  // ****************************************************************
  function automatic logic [asp_pkg::GAP_W-1:0] gap_of(input logic [1:0] m);
    case (m)
      asp_pkg::ASP_PWR_FULL: gap_of = asp_pkg::GAP_W'(asp_pkg::GAP_FULL_MCLK);
      asp_pkg::ASP_PWR_MID:  gap_of = asp_pkg::GAP_W'(asp_pkg::GAP_MID_MCLK);
      default:               gap_of = asp_pkg::GAP_W'(asp_pkg::GAP_LOW_MCLK);
    endcase
  endfunction

  function automatic logic [asp_pkg::PULSE_W-1:0] pulse_of(input logic [1:0] m);
    case (m)
      asp_pkg::ASP_PWR_FULL: pulse_of = asp_pkg::PULSE_W'(asp_pkg::PULSE_FULL_CYC);
      asp_pkg::ASP_PWR_MID:  pulse_of = asp_pkg::PULSE_W'(asp_pkg::PULSE_MID_CYC);
      default:               pulse_of = asp_pkg::PULSE_W'(asp_pkg::PULSE_LOW_CYC);
    endcase
  endfunction

  // ****************************************************************
  // link side and crossings
  // ****************************************************************
  logic [WORD_BITS-1:0]         data_reg;
  logic                         link_bit;
  logic                         link_done;
  logic                         cs_s1_reg, cs_s2_reg, cs_prev_reg;
  logic                         dn_s1_reg, dn_s2_reg, dn_prev_reg;

  asp_link #(.WORD_BITS(WORD_BITS)) u_link (
    .sclk    (sclk),
    .cs_n    (cs_n),
    .word    (data_reg),
    .bit_out (link_bit),
    .done    (link_done)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      cs_s1_reg   <= 1'b1;
      cs_s2_reg   <= 1'b1;
      cs_prev_reg <= 1'b1;
      dn_s1_reg   <= 1'b0;
      dn_s2_reg   <= 1'b0;
      dn_prev_reg <= 1'b0;
    end else begin
      cs_s1_reg   <= cs_n;
      cs_s2_reg   <= cs_s1_reg;
      cs_prev_reg <= cs_s2_reg;
      dn_s1_reg   <= link_done;
      dn_s2_reg   <= dn_s1_reg;
      dn_prev_reg <= dn_s2_reg;
    end
  end

  logic cs_fall, cs_rise, word_done;
  assign cs_fall   = cs_prev_reg & ~cs_s2_reg;
  assign cs_rise   = ~cs_prev_reg & cs_s2_reg;
  assign word_done = dn_s2_reg & ~dn_prev_reg;

  // ****************************************************************
  // gap between operations and frame acceptance
  // ****************************************************************
  logic [asp_pkg::GAP_W-1:0] gap_cnt_reg;
  logic                      gap_ok_reg;
  logic                      take_reg;
  logic                      read_once_reg;
  logic                      take_next;

  // the clock counts as master clock; the serial clock never reaches this counter
  always_ff @(posedge clk) begin
    if (srst) begin
      gap_cnt_reg <= '0;
      gap_ok_reg  <= 1'b1;
    end else if (cs_rise) begin
      gap_cnt_reg <= gap_of(power_mode);
      gap_ok_reg  <= 1'b0;
    end else if (cs_s2_reg && gap_cnt_reg != '0) begin
      gap_cnt_reg <= gap_cnt_reg - asp_pkg::GAP_W'(1);
    end else if (cs_s2_reg) begin
      gap_ok_reg  <= 1'b1;
    end
  end

  asp_pkg::asp_rdy_t state_reg;

  // a used word in continuous read mode is refused
  assign take_next = gap_ok_reg && state_reg != asp_pkg::ASP_RDY_IDLE &&
                     !(conv_mode == asp_pkg::ASP_CONV_CREAD && read_once_reg);

  always_ff @(posedge clk) begin
    if (srst) begin
      take_reg      <= 1'b0;
      frame_refused <= 1'b0;
    end else begin
      frame_refused <= cs_fall & ~take_next;
      if (cs_fall) begin
        take_reg <= take_next;
      end else if (cs_rise) begin
        take_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // ready line and output register
  // ****************************************************************
  logic                       pend_reg;
  logic [WORD_BITS-1:0]       pend_data_reg;
  logic [asp_pkg::PULSE_W-1:0] pulse_cnt_reg;
  logic                       apply;
  logic                       read_done;

  // the output register never changes under an open frame
  assign apply     = (pend_reg | conv_valid) & cs_s2_reg;
  assign read_done = word_done & take_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      pend_reg      <= 1'b0;
      pend_data_reg <= '0;
    end else if (conv_valid) begin
      pend_reg      <= ~cs_s2_reg;
      pend_data_reg <= conv_data;
    end else if (apply) begin
      pend_reg      <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      data_reg      <= '0;
      read_once_reg <= 1'b0;
    end else if (apply) begin
      data_reg      <= conv_valid ? conv_data : pend_data_reg;
      read_once_reg <= 1'b0;
    end else if (read_done) begin
      read_once_reg <= 1'b1;
    end
  end

  // a fresh result beats a read finishing in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg     <= asp_pkg::ASP_RDY_IDLE;
      pulse_cnt_reg <= '0;
    end else begin
      case (state_reg)
        asp_pkg::ASP_RDY_VALID: begin
          if (apply) begin
            state_reg     <= asp_pkg::ASP_RDY_PULSE;
            pulse_cnt_reg <= pulse_of(power_mode);
          end else if (read_done) begin
            state_reg     <= asp_pkg::ASP_RDY_READ;
          end
        end
        asp_pkg::ASP_RDY_PULSE: begin
          if (pulse_cnt_reg > asp_pkg::PULSE_W'(1)) begin
            pulse_cnt_reg <= pulse_cnt_reg - asp_pkg::PULSE_W'(1);
          end else begin
            state_reg     <= asp_pkg::ASP_RDY_VALID;
          end
        end
        asp_pkg::ASP_RDY_IDLE, asp_pkg::ASP_RDY_READ: begin
          if (apply) begin
            state_reg <= asp_pkg::ASP_RDY_VALID;
          end
        end
        default: begin
          state_reg <= asp_pkg::ASP_RDY_IDLE;
        end
      endcase
    end
  end

  assign ready_n = (state_reg != asp_pkg::ASP_RDY_VALID);

  // ****************************************************************
  // data to ready switch on the shared pin
  // ****************************************************************
  logic [asp_pkg::RDY_W-1:0] sw_cnt_reg;
  logic                      sw_run_reg;
  logic                      switched_reg;
  logic                      show_data;

  // the two synchroniser stages already cost 100 ns, so the counter adds the rest
  always_ff @(posedge clk) begin
    if (srst || cs_rise || cs_fall) begin
      sw_cnt_reg   <= '0;
      sw_run_reg   <= 1'b0;
      switched_reg <= 1'b0;
    end else if (word_done && !cs_hold_bit) begin
      sw_cnt_reg   <= ready_edge_delay_bit ? asp_pkg::RDY_W'(asp_pkg::RDY_SLOW_CYC - 2)
                                           : asp_pkg::RDY_W'(asp_pkg::RDY_FAST_CYC - 1);
      sw_run_reg   <= 1'b1;
    end else if (sw_run_reg && sw_cnt_reg != '0) begin
      sw_cnt_reg   <= sw_cnt_reg - asp_pkg::RDY_W'(1);
    end else if (sw_run_reg) begin
      switched_reg <= 1'b1;
      sw_run_reg   <= 1'b0;
    end
  end

  // before the accept decision lands, the open gap and a live word decide
  assign show_data = cs_s2_reg ? (gap_ok_reg && state_reg != asp_pkg::ASP_RDY_IDLE) : take_reg;
  assign dout_o    = (show_data && !switched_reg) ? link_bit : ready_n;
  // pad enable follows the pin itself; a synchronised copy would miss the 80 ns release
  assign dout_oe   = ~cs_n;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_fresh_in_valid;
    state_reg == asp_pkg::ASP_RDY_VALID && apply;
  endsequence

  sequence s_slow_switch;
    word_done && !cs_hold_bit && ready_edge_delay_bit && cs_s2_reg == 1'b0 ##1 !cs_rise && !cs_fall;
  endsequence

  a_pulse_high_len: assert property (s_fresh_in_valid |=> ready_n [*8])
    else $error("ready pulse shorter than expected");
  a_pulse_ends_low: assert property (state_reg == asp_pkg::ASP_RDY_PULSE && pulse_cnt_reg == 1 && !read_done
                                     |=> !ready_n)
    else $error("ready did not return low after pulse");
  a_read_sets_rdy: assert property (read_done && !apply && state_reg == asp_pkg::ASP_RDY_VALID |=> ready_n)
    else $error("ready stayed low after read");
  a_reread_taken: assert property (cs_fall && gap_ok_reg && conv_mode != asp_pkg::ASP_CONV_CREAD &&
                                   state_reg == asp_pkg::ASP_RDY_READ |=> take_reg)
    else $error("re-read refused");
  a_once_only: assert property (cs_fall && conv_mode == asp_pkg::ASP_CONV_CREAD && read_once_reg
                                |=> !take_reg && frame_refused)
    else $error("word presented twice in continuous read");
  a_slow_switch: assert property (s_slow_switch |-> !switched_reg ##1 !switched_reg ##1 switched_reg)
    else $error("ready switch timing wrong with delay bit");
  a_hold_lsb: assert property (cs_hold_bit && !cs_s2_reg && !cs_fall |-> !switched_reg)
    else $error("pin left data while hold bit set");
  a_release_pin: assert property (cs_n |-> !dout_oe)
    else $error("pin still driven after chip select rose");
  a_gap_blocks: assert property (cs_rise |=> !gap_ok_reg [*2])
    else $error("gap not enforced");

endmodule
`default_nettype wire

// >>> verilog/asp_fix_note.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> testbench/asp_host.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// host master: gated serial clock, word capture
// ****************************************************************
module asp_host (
  output logic      sclk,
  output logic      cs_n,
  input  wire logic dout_o,
  input  wire logic dout_oe,
  output logic      rx_valid
);
  localparam int W = asp_pkg::WORD_BITS;
  logic         lclk     = 1'b1;
  logic         run      = 1'b0;
  logic         last     = 1'b0;
  logic         tail     = 1'b0;
  logic [W-1:0] rx_data  = '0;
  wire          pin;

  // a released pin must not look like it still carries the last bit
  assign pin  = dout_oe ? dout_o : ~last;
  // clock stands high outside frames
  assign sclk = run ? lclk : 1'b1;
  // a rising chip select at start clears the link counters before the first frame
  initial begin
    cs_n = 1'b0;
    #1 cs_n = 1'b1;
  end
  initial rx_valid = 1'b0;

  // odd offset keeps link edges clear of the system clock edges
  initial begin
    #7.3;
    forever #16 lclk = ~lclk;
  end

  always @(posedge lclk) begin
    if (dout_oe) begin
      last <= dout_o;
    end
  end

  task automatic xfer(input bit chk, input int hold);
    @(posedge lclk);
    cs_n = 1'b0;
    repeat (8) @(posedge lclk);
    run = 1'b1;
    // device launches on the falling edge, host takes the bit on the rising one
    for (int i = 0; i < W; i++) begin
      @(posedge lclk);
      rx_data = {rx_data[W-2:0], pin};
    end
    run = 1'b0;
    repeat (hold) @(posedge lclk);
    tail = pin;
    cs_n = 1'b1;
    if (chk) begin
      rx_valid = 1'b1;
      #1 rx_valid = 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("Error at %0t ns: got %h expected %h", $time, (a), (b)); end end

module tb_top;
  localparam int W = asp_pkg::WORD_BITS;
  logic         clk                  = 1'b0;
  logic         srst                 = 1'b1;
  logic         sclk;
  logic         cs_n;
  logic [1:0]   power_mode           = asp_pkg::ASP_PWR_FULL;
  logic [1:0]   conv_mode            = asp_pkg::ASP_CONV_CONT;
  logic         cs_hold_bit          = 1'b0;
  logic         ready_edge_delay_bit = 1'b0;
  logic [W-1:0] conv_data            = '0;
  logic         conv_valid           = 1'b0;
  logic         dout_o;
  logic         dout_oe;
  logic         ready_n;
  logic         frame_refused;
  logic         rx_valid;
  int           bad_count            = 0;
  int           n_compared           = 0;
  int           ref_cnt              = 0;
  int           cnt;
  int           r0;
  logic [W-1:0] d;
  logic [W-1:0] exp_v;
  logic [W-1:0] exp_q [$];
  logic [1:0]   pm [3] = '{asp_pkg::ASP_PWR_FULL, asp_pkg::ASP_PWR_MID, asp_pkg::ASP_PWR_LOW};
  int           gp [3] = '{asp_pkg::GAP_FULL_MCLK, asp_pkg::GAP_MID_MCLK, asp_pkg::GAP_LOW_MCLK};
  int           pl [3] = '{asp_pkg::PULSE_FULL_CYC, asp_pkg::PULSE_MID_CYC, asp_pkg::PULSE_LOW_CYC};

  always #25 clk = ~clk;

  asp_port DUT (.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .power_mode(power_mode),
    .conv_mode(conv_mode), .cs_hold_bit(cs_hold_bit), .ready_edge_delay_bit(ready_edge_delay_bit),
    .conv_data(conv_data), .conv_valid(conv_valid), .dout_o(dout_o), .dout_oe(dout_oe),
    .ready_n(ready_n), .frame_refused(frame_refused));

  asp_host host (.sclk(sclk), .cs_n(cs_n), .dout_o(dout_o), .dout_oe(dout_oe), .rx_valid(rx_valid));

  // ****************************************************************
  // result watcher
  // ****************************************************************
  always @(posedge clk) begin
    if (frame_refused === 1'b1) ref_cnt++;
  end

  always @(posedge rx_valid) begin
    exp_v = exp_q.pop_front();
    `CHK(host.rx_data, exp_v)
  end

  // ****************************************************************
  // drivers
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic conv(input logic [W-1:0] v);
    conv_data = v;
    conv_valid = 1'b1;
    tick(1);
    conv_valid = 1'b0;
  endtask

  task automatic rd(input bit ok);
    if (ok) exp_q.push_back(d);
    host.xfer(ok, 10);
    tick(2);
  endtask

  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #400000;
    bad_count++;
    test_done();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    d = W'($urandom(62));
    tick(12);
    `CHK(ready_n, 1'b1)
    `CHK(frame_refused, 1'b0)
    srst = 1'b0;
    tick(4);
    for (int k = 0; k < 2; k++) begin
      ready_edge_delay_bit = k[0];
      d = W'($urandom);
      conv(d);
      `CHK(ready_n, 1'b0)
      rd(1'b1);
      `CHK(host.tail, 1'b1)
      `CHK(ready_n, 1'b1)
      `CHK(dout_oe, 1'b0)
      tick(30);
    end
    $display("test fresh_read done");
    // re-reads with no conversion pending, so no output update is near
    for (int m = 0; m < 2; m++) begin
      conv_mode = m[1:0];
      cs_hold_bit = 1'b1;
      rd(1'b1);
      `CHK(host.tail, d[0])
      cs_hold_bit = 1'b0;
      tick(30);
    end
    $display("test reread done");
    conv_mode = asp_pkg::ASP_CONV_CREAD;
    d = W'($urandom);
    conv(d);
    tick(8);
    rd(1'b1);
    tick(30);
    r0 = ref_cnt;
    rd(1'b0);
    `CHK(ref_cnt, r0 + 1)
    conv_mode = asp_pkg::ASP_CONV_CONT;
    $display("test single_word done");
    d = W'($urandom);
    conv(d);
    for (int m = 0; m < 3; m++) begin
      power_mode = pm[m];
      tick(30);
      rd(1'b1);
      // reopen about eight clocks after the last frame: enough only in full power
      tick(asp_pkg::GAP_FULL_MCLK + 3);
      r0 = ref_cnt;
      rd(gp[m] <= asp_pkg::GAP_FULL_MCLK);
      `CHK(ref_cnt, r0 + (gp[m] > asp_pkg::GAP_FULL_MCLK))
    end
    $display("test gap done");
    for (int m = 0; m < 3; m++) begin
      power_mode = pm[m];
      conv(d);
      tick(1);
      d = W'($urandom);
      conv(d);
      cnt = 0;
      while (ready_n === 1'b1 && cnt < 2000) begin
        tick(1);
        cnt++;
      end
      `CHK(cnt >= pl[m] - 1 && cnt <= pl[m] + 1, 1'b1)
      rd(1'b1);
      tick(30);
    end
    $display("test ready_pulse done");
    test_done();
  end
endmodule

`default_nettype wire
